// file: rtl/oad_pkg.sv
package oad_pkg;

   // Operand addressing methods
   typedef enum logic [2:0]
   {
      MD_REG = 3'b000,
      MD_DIR = 3'b001,
      MD_IND = 3'b010,
      MD_IMM = 3'b011,
      MD_BIX = 3'b100
   } oad_mode_t;

   // Address spaces an operand can land in
   typedef enum logic [2:0]
   {
      SP_NONE = 3'b000,
      SP_IRAM = 3'b001,
      SP_SFR = 3'b010,
      SP_AUX = 3'b011,
      SP_XDATA = 3'b100,
      SP_CODE = 3'b101,
      SP_IMM = 3'b110
   } oad_space_t;

   // Status word location and reset value
   localparam logic [7:0] PSW_ADDR = 8'hd0;
   localparam logic [7:0] PSW_RESET = 8'h00;
   // Bank select field positions in the status word
   localparam int BANK_LOW_BIT = 3;
   localparam int BANK_HIGH_BIT = 4;
   // Registers per bank and number of banks
   localparam int REGS_PER_BANK = 8;
   localparam int NUM_BANKS = 4;
   // First direct address of the special function registers
   localparam logic [7:0] SFR_BASE = 8'h80;
   // First byte of the bit-addressable RAM
   localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
   // Highest on-chip auxiliary RAM location (1791)
   localparam logic [15:0] AUX_TOP = 16'h06ff;
   // Auxiliary page code that maps to no memory
   localparam logic [2:0] AUX_PAGE_BAD = 3'h7;
   // Request to answer delay in clock cycles
   localparam int DECODE_LATENCY = 2;

endpackage

// file: rtl/oad_bank_ram.sv
module oad_bank_ram
   #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int ADDR_W = 5
   )
   (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wr_en,
   input wire logic [ADDR_W-1:0] i_wr_addr,
   input wire logic [WIDTH-1:0] i_wr_data,
   input wire logic [ADDR_W-1:0] i_rd_addr,
   output logic [WIDTH-1:0] o_rd_data
   );

   // Storage array, no reset
   logic [WIDTH-1:0] mem [DEPTH];

   // Write port
   always_ff @(posedge i_clk)
   begin
      if (i_wr_en)
      begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   // Registered read port, old data on collision
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_rd_data <= '0;
      end
      else
      begin
         o_rd_data <= mem[i_rd_addr];
      end
   end

endmodule

// file: rtl/oad_decoder.sv
module oad_decoder
   import oad_pkg::*;
   #(
   parameter int BANK_WORDS = REGS_PER_BANK * NUM_BANKS
   )
   (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire oad_mode_t i_mode,
   input wire logic i_dest,
   input wire logic i_move,
   input wire logic i_xmove,
   input wire logic i_xdptr,
   input wire logic i_bit_op,
   input wire logic [2:0] i_reg_sel,
   input wire logic [7:0] i_direct,
   input wire logic [7:0] i_imm,
   input wire logic [15:0] i_dptr,
   input wire logic [15:0] i_pc,
   input wire logic i_base_pc,
   input wire logic [7:0] i_index,
   input wire logic i_aux_ram_disable,
   input wire logic [2:0] i_aux_page_select,
   input wire logic i_wb,
   input wire logic [7:0] i_wb_data,
   output logic o_valid,
   output oad_space_t o_space,
   output logic [15:0] o_addr,
   output logic o_bit,
   output logic [2:0] o_bit_pos,
   output logic [7:0] o_imm,
   output logic o_rd_dest,
   output logic o_wr_ok,
   output logic o_err,
   output oad_mode_t o_mode,
   output logic [7:0] o_psw
   );

   // Bank RAM address of a register in the active bank
   function automatic logic [4:0] bank_addr(input logic [1:0] bank,
                                            input logic [2:0] sel);
      bank_addr = {bank, sel};
   endfunction

   // Captured request fields
   logic s1_valid;
   oad_mode_t s1_mode;
   logic s1_dest;
   logic s1_move;
   logic s1_xmove;
   logic s1_xdptr;
   logic s1_bit_op;
   logic [2:0] s1_reg_sel;
   logic [7:0] s1_direct;
   logic [7:0] s1_imm;
   logic [15:0] s1_base;
   logic [7:0] s1_index;
   logic s1_ard;
   logic [2:0] s1_page;
   // Active bank as it stood when the request was taken
   logic [1:0] s1_bank;
   // Pointer register value read from the bank RAM
   logic [7:0] ptr_value;
   // Active bank from the status word
   logic [1:0] bank;
   // Bank RAM write strobe and address
   logic bank_wr;
   logic [4:0] bank_wr_addr;
   // Decoded next answer
   oad_space_t next_space;
   logic [15:0] next_addr;
   logic next_bit;
   logic [2:0] next_bit_pos;
   logic next_err;
   logic next_wr_ok;
   logic next_rd_dest;

   assign bank = o_psw[BANK_HIGH_BIT:BANK_LOW_BIT];

   // Capture a request
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         s1_valid <= 1'b0;
         s1_mode <= MD_REG;
         s1_dest <= 1'b0;
         s1_move <= 1'b0;
         s1_xmove <= 1'b0;
         s1_xdptr <= 1'b0;
         s1_bit_op <= 1'b0;
         s1_reg_sel <= '0;
         s1_direct <= '0;
         s1_imm <= '0;
         s1_base <= '0;
         s1_index <= '0;
         s1_ard <= 1'b0;
         s1_page <= '0;
         s1_bank <= '0;
      end
      else
      begin
         s1_valid <= i_req;
         if (i_req)
         begin
            s1_mode <= i_mode;
            s1_dest <= i_dest;
            s1_move <= i_move;
            s1_xmove <= i_xmove;
            s1_xdptr <= i_xdptr;
            s1_bit_op <= i_bit_op;
            s1_reg_sel <= i_reg_sel;
            s1_direct <= i_direct;
            s1_imm <= i_imm;
            // Program counter base only for table look-ups
            s1_base <= (i_base_pc && (i_mode == MD_BIX)) ? i_pc : i_dptr;
            s1_index <= i_index;
            s1_ard <= i_aux_ram_disable;
            s1_page <= i_aux_page_select;
            // Bank before any same-cycle status write
            s1_bank <= bank;
         end
      end
   end

   // Write-back into bank RAM when last target is a bank byte
   // banks occupy 0-31
   assign bank_wr = i_wb && o_wr_ok && (o_space == SP_IRAM) && !o_bit
                    && (o_addr < 16'(BANK_WORDS));
   assign bank_wr_addr = o_addr[4:0];

   // Bank RAM mirror, read port fetches pointer R0 or R1
   oad_bank_ram
      #(
      .WIDTH(8),
      .DEPTH(BANK_WORDS),
      .ADDR_W(5)
      )
   u_bank_ram
      (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_wr_en(bank_wr),
      .i_wr_addr(bank_wr_addr),
      .i_wr_data(i_wb_data),
      .i_rd_addr(bank_addr(bank, {2'b00, i_reg_sel[0]})),
      .o_rd_data(ptr_value)
      );

   // Status word: direct byte or bit writes at its address
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_psw <= PSW_RESET;
      end
      else if (i_wb && o_wr_ok && (o_space == SP_SFR))
      begin
         if (o_bit && (o_addr[7:0] == PSW_ADDR))
         begin
            o_psw[o_bit_pos] <= i_wb_data[0];
         end
         else if (!o_bit && (o_addr[7:0] == PSW_ADDR))
         begin
            o_psw <= i_wb_data;
         end
      end
   end

   // Operand decode
   always_comb
   begin
      next_space = SP_NONE;
      next_addr = '0;
      next_bit = 1'b0;
      next_bit_pos = '0;
      next_err = 1'b0;
      case (s1_mode)
         MD_REG:
         begin
            next_space = SP_IRAM;
            next_addr = {11'h000, bank_addr(s1_bank, s1_reg_sel)};
         end
         MD_DIR:
         begin
            if (s1_bit_op)
            begin
               next_bit = 1'b1;
               next_bit_pos = s1_direct[2:0];
               if (s1_direct < SFR_BASE)
               begin
                  next_space = SP_IRAM;
                  next_addr = {8'h00,
                               BIT_BYTE_BASE + {4'h0, s1_direct[6:3]}};
               end
               else
               begin
                  next_space = SP_SFR;
                  next_addr = {8'h00, s1_direct[7:3], 3'b000};
               end
            end
            else if (s1_direct < SFR_BASE)
            begin
               next_space = SP_IRAM;
               next_addr = {8'h00, s1_direct};
            end
            else
            begin
               next_space = SP_SFR;
               next_addr = {8'h00, s1_direct};
            end
         end
         MD_IND:
         begin
            if (s1_xmove && s1_xdptr)
            begin
               if (s1_ard || (s1_base > AUX_TOP))
               begin
                  next_space = SP_XDATA;
               end
               else
               begin
                  next_space = SP_AUX;
               end
               next_addr = s1_base;
            end
            else if (s1_xmove)
            begin
               if (s1_ard)
               begin
                  next_space = SP_XDATA;
                  next_addr = {8'h00, ptr_value};
               end
               else if (s1_page == AUX_PAGE_BAD)
               begin
                  next_err = 1'b1;
               end
               else
               begin
                  next_space = SP_AUX;
                  next_addr = {5'h00, s1_page, ptr_value};
               end
            end
            else
            begin
               // indirect reaches all 256 RAM bytes
               next_space = SP_IRAM;
               next_addr = {8'h00, ptr_value};
            end
         end
         MD_IMM:
         begin
            next_space = SP_IMM;
         end
         MD_BIX:
         begin
            next_space = SP_CODE;
            next_addr = s1_base + {8'h00, s1_index};
         end
         default:
         begin
            next_err = 1'b1;
         end
      endcase
      // immediate and base-index cannot be written
      if (s1_dest && ((s1_mode == MD_IMM) || (s1_mode == MD_BIX)))
      begin
         next_err = 1'b1;
      end
      next_wr_ok = s1_dest && !next_err && (next_space != SP_NONE)
                   && ((s1_mode == MD_REG) || (s1_mode == MD_DIR)
                       || (s1_mode == MD_IND));
      next_rd_dest = next_wr_ok && !s1_move;
   end

   // Answer registers, all but o_valid held until the next decode
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_valid <= 1'b0;
         o_space <= SP_NONE;
         o_addr <= '0;
         o_bit <= 1'b0;
         o_bit_pos <= '0;
         o_imm <= '0;
         o_rd_dest <= 1'b0;
         o_wr_ok <= 1'b0;
         o_err <= 1'b0;
         o_mode <= MD_REG;
      end
      else
      begin
         o_valid <= s1_valid;
         if (s1_valid)
         begin
            o_space <= next_space;
            o_addr <= next_addr;
            o_bit <= next_bit;
            o_bit_pos <= next_bit_pos;
            o_imm <= s1_imm;
            o_rd_dest <= next_rd_dest;
            o_wr_ok <= next_wr_ok;
            o_err <= next_err;
            o_mode <= s1_mode;
         end
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   // Answer follows a request by the decode latency
   property p_latency;
      i_req |-> ##2 o_valid;
   endproperty
   a_latency: assert property (p_latency)
      else $error("answer missing two cycles after request");

   property p_dest_methods;
      o_valid && o_wr_ok |-> o_mode inside {MD_REG, MD_DIR, MD_IND};
   endproperty
   a_dest_methods: assert property (p_dest_methods)
      else $error("write target from an unwritable method");

   property p_rmw;
      i_req && i_dest && !i_move && (i_mode == MD_DIR) |-> ##2 o_rd_dest;
   endproperty
   a_rmw: assert property (p_rmw)
      else $error("destination not read for non-move");

   property p_reg_addr;
      i_req && (i_mode == MD_REG) |-> ##2 (o_space == SP_IRAM)
         && (o_addr == {11'h000, $past(bank, 2), $past(i_reg_sel, 2)});
   endproperty
   a_reg_addr: assert property (p_reg_addr)
      else $error("register address not bank times eight plus field");

   property p_low_direct;
      i_req && (i_mode == MD_DIR) && !i_bit_op && !i_direct[7]
         |-> ##2 (o_space == SP_IRAM) && (o_addr[7:0] == $past(i_direct, 2));
   endproperty
   a_low_direct: assert property (p_low_direct)
      else $error("low direct address not in RAM");

   property p_high_ram;
      o_valid && (o_space == SP_IRAM) && o_addr[7] && !o_bit
         |-> (o_mode == MD_IND);
   endproperty
   a_high_ram: assert property (p_high_ram)
      else $error("upper RAM reached other than indirectly");

   property p_aux;
      o_valid && (o_space == SP_AUX)
         |-> (o_mode == MD_IND) && (o_addr <= AUX_TOP);
   endproperty
   a_aux: assert property (p_aux)
      else $error("aux RAM access out of range or method");

   property p_sfr;
      o_valid && (o_space == SP_SFR) |-> (o_mode == MD_DIR) && o_addr[7];
   endproperty
   a_sfr: assert property (p_sfr)
      else $error("special register selected other than direct");

   property p_xdata;
      o_valid && (o_space == SP_XDATA) |-> (o_mode == MD_IND);
   endproperty
   a_xdata: assert property (p_xdata)
      else $error("external data reached other than indirectly");

   property p_code;
      o_valid && (o_space == SP_CODE) |-> (o_mode == MD_BIX);
   endproperty
   a_code: assert property (p_code)
      else $error("code space reached without base plus index");

   property p_bit_map;
      i_req && (i_mode == MD_DIR) && i_bit_op && !i_direct[7]
         |-> ##2 o_bit && (o_addr[7:0] == BIT_BYTE_BASE
             + {4'h0, $past(i_direct[6:3], 2)});
   endproperty
   a_bit_map: assert property (p_bit_map)
      else $error("bit address mapped to wrong RAM byte");

   property p_ard;
      i_req && (i_mode == MD_IND) && i_xmove && i_aux_ram_disable
         |-> ##2 (o_space == SP_XDATA);
   endproperty
   a_ard: assert property (p_ard)
      else $error("disabled aux RAM still selected");

   property p_page;
      i_req && (i_mode == MD_IND) && i_xmove && !i_xdptr
         && !i_aux_ram_disable && (i_aux_page_select != AUX_PAGE_BAD)
         |-> ##2 (o_space == SP_AUX)
             && (o_addr[10:8] == $past(i_aux_page_select, 2));
   endproperty
   a_page: assert property (p_page)
      else $error("aux page not taken from page select");

   property p_sfr_bit;
      i_req && (i_mode == MD_DIR) && i_bit_op && i_direct[7]
         |-> ##2 (o_space == SP_SFR) && (o_addr[2:0] == 3'b000);
   endproperty
   a_sfr_bit: assert property (p_sfr_bit)
      else $error("special register bit byte not aligned");

   c_reg: cover property (o_valid && (o_mode == MD_REG));
   c_aux: cover property (o_valid && (o_space == SP_AUX));
   c_bit: cover property (o_valid && o_bit);
   c_xdata: cover property (o_valid && (o_space == SP_XDATA));

endmodule

// file: sim/oad_seq_model.sv
// Sequencer side: writes a result back after a destination decode
module oad_seq_model
   (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic i_wr_ok,
   input wire logic i_rd_dest,
   input wire logic i_want,
   input wire logic i_slow,
   input wire logic [7:0] i_data,
   output logic o_wb,
   output logic [7:0] o_wb_data
   );
   timeunit 1ns;
   timeprecision 1ns;

   // Cycles left until the write-back pulse
   logic [1:0] wait_cnt;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         wait_cnt <= 2'h0;
      else if (i_valid && i_wr_ok && i_want)
         wait_cnt <= (i_slow || i_rd_dest) ? 2'h2 : 2'h1;
      else if (wait_cnt != 2'h0)
         wait_cnt <= wait_cnt - 2'h1;
   end

   // One-cycle pulse; data inverted while idle
   assign o_wb = (wait_cnt == 2'h1);
   assign o_wb_data = o_wb ? i_data : ~i_data;
endmodule

// file: sim/test_operand_address_decode.sv
`define CHK(a, b) \
   begin \
      checks++; \
      if ((a) !== (b)) \
      begin \
         bad_count++; \
         $display("ERROR %0t got %h want %h", $time, a, b); \
      end \
   end

module test_operand_address_decode;
   timeunit 1ns;
   timeprecision 1ns;
   import oad_pkg::*;

   // Design inputs
   logic i_clk = 0, i_rst_n = 0, i_req = 0, i_dest = 0, i_move = 0;
   logic i_xmove = 0, i_xdptr = 0, i_bit_op = 0, i_base_pc = 0;
   logic i_aux_ram_disable = 0, i_wb, want = 0, slow = 0;
   oad_mode_t i_mode = MD_REG;
   logic [2:0] i_reg_sel = 0, i_aux_page_select = 0;
   logic [7:0] i_direct = 0, i_imm = 0, i_index = 0, i_wb_data, wd = 0;
   logic [15:0] i_dptr = 0, i_pc = 0;
   // Design outputs
   logic o_valid, o_bit, o_rd_dest, o_wr_ok, o_err;
   oad_space_t o_space;
   oad_mode_t o_mode;
   logic [15:0] o_addr;
   logic [2:0] o_bit_pos;
   logic [7:0] o_imm, o_psw;
   // Reference model state and expectations
   int bad_count = 0, checks = 0;
   logic [7:0] m_psw = 0, m_ram [32], ptr;
   oad_space_t e_sp;
   logic [15:0] e_addr;
   logic [2:0] e_pos;
   logic e_bit, e_err, e_wr;

   oad_decoder i_oad_decoder (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_req(i_req), .i_mode(i_mode), .i_dest(i_dest), .i_move(i_move),
      .i_xmove(i_xmove), .i_xdptr(i_xdptr), .i_bit_op(i_bit_op),
      .i_reg_sel(i_reg_sel), .i_direct(i_direct), .i_imm(i_imm),
      .i_dptr(i_dptr), .i_pc(i_pc), .i_base_pc(i_base_pc),
      .i_index(i_index), .i_aux_ram_disable(i_aux_ram_disable),
      .i_aux_page_select(i_aux_page_select), .i_wb(i_wb),
      .i_wb_data(i_wb_data), .o_valid(o_valid), .o_space(o_space),
      .o_addr(o_addr), .o_bit(o_bit), .o_bit_pos(o_bit_pos),
      .o_imm(o_imm), .o_rd_dest(o_rd_dest), .o_wr_ok(o_wr_ok),
      .o_err(o_err), .o_mode(o_mode), .o_psw(o_psw));

   oad_seq_model i_oad_seq_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_valid(o_valid), .i_wr_ok(o_wr_ok), .i_rd_dest(o_rd_dest),
      .i_want(want), .i_slow(slow), .i_data(wd), .o_wb(i_wb),
      .o_wb_data(i_wb_data));

   // Clock, 100 ns period
   initial
   begin
      forever #50 i_clk = ~i_clk;
   end

   // Expected answer from the current request fields
   task automatic calc();
      logic [4:0] bk;
      bk = {m_psw[4:3], 3'h0};
      ptr = m_ram[bk + i_reg_sel[0]];
      {e_bit, e_err, e_pos, e_addr} = '0;
      case (i_mode)
         MD_REG:
         begin
            e_sp = SP_IRAM;
            e_addr = {11'h0, bk + {2'h0, i_reg_sel}};
         end
         MD_DIR:
         begin
            e_sp = i_direct[7] ? SP_SFR : SP_IRAM;
            e_addr = {8'h0, i_direct};
            e_bit = i_bit_op;
            e_pos = i_bit_op ? i_direct[2:0] : 3'h0;
            if (i_bit_op)
               e_addr = i_direct[7] ? {8'h0, i_direct & 8'hf8} :
                  {8'h0, 8'h20 + {4'h0, i_direct[6:3]}};
         end
         MD_IND:
         begin
            e_sp = SP_IRAM;
            e_addr = {8'h0, ptr};
            if (i_xmove && i_xdptr)
            begin
               e_addr = i_dptr;
               e_sp = (!i_aux_ram_disable && i_dptr <= 16'h06ff) ?
                  SP_AUX : SP_XDATA;
            end
            else if (i_xmove && i_aux_ram_disable)
               e_sp = SP_XDATA;
            else if (i_xmove && i_aux_page_select == 3'h7)
            begin
               e_sp = SP_NONE;
               e_err = 1'b1;
            end
            else if (i_xmove)
            begin
               e_sp = SP_AUX;
               e_addr = {5'h0, i_aux_page_select, ptr};
            end
         end
         MD_IMM:
            e_sp = SP_IMM;
         default:
         begin
            e_sp = SP_CODE;
            e_addr = (i_base_pc ? i_pc : i_dptr) + {8'h0, i_index};
         end
      endcase
      e_err = e_err || (i_dest && i_mode > MD_IND);
      e_wr = i_dest && !e_err;
   endtask

   // One decode, its checks, write-back and model update
   task automatic op();
      calc();
      i_req = 1;
      @(posedge i_clk);
      #1 i_req = 0;
      `CHK(o_valid, 1'b0)
      @(posedge i_clk);
      #1 `CHK(o_valid, 1'b1)
      `CHK(o_mode, i_mode)
      `CHK(o_space, e_sp)
      if (e_sp != SP_NONE && e_sp != SP_IMM)
         `CHK(o_addr, e_addr)
      if (e_sp == SP_IMM)
         `CHK(o_imm, i_imm)
      `CHK(o_bit, e_bit)
      if (e_bit)
         `CHK(o_bit_pos, e_pos)
      `CHK(o_err, e_err)
      `CHK(o_wr_ok, e_wr)
      `CHK(o_rd_dest, e_wr && !i_move)
      `CHK(o_psw, m_psw)
      @(posedge i_clk);
      #1 `CHK(o_valid, 1'b0)
      repeat (3) @(posedge i_clk);
      #1;
      if (want && e_wr && e_sp == SP_SFR && e_addr == 16'h00d0)
         if (e_bit)
            m_psw[e_pos] = wd[0];
         else
            m_psw = wd;
      if (want && e_wr && e_sp == SP_IRAM && !e_bit && e_addr < 32)
         m_ram[e_addr[4:0]] = wd;
   endtask

   // Verdict and end of run
   task automatic wrap_up();
      if (bad_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Watchdog
   initial
   begin
      #2000000;
      bad_count++;
      wrap_up();
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'hc23e));
      repeat (8) @(posedge i_clk);
      #1 i_rst_n = 1;
      `CHK(o_psw, 8'h00)
      `CHK(o_space, SP_NONE)
      {want, i_dest, i_move} = 3'h7;
      // Fill every bank through the status word select
      for (int b = 0; b < 4; b++)
      begin
         i_mode = MD_DIR;
         i_direct = 8'hd0;
         wd = {3'h0, 2'(b), 3'h0};
         op();
         for (int r = 0; r < 8; r++)
         begin
            i_mode = MD_REG;
            i_reg_sel = 3'(r);
            wd = 8'($urandom);
            op();
         end
      end
      // Random operands across all methods and spaces
      for (int n = 0; n < 400; n++)
      begin
         i_mode = oad_mode_t'($urandom_range(4));
         {i_dest, i_move, want, slow} = 4'($urandom);
         i_xmove = (i_mode == MD_IND) && $urandom_range(1);
         i_xdptr = i_xmove && $urandom_range(1);
         i_bit_op = (i_mode == MD_DIR) && $urandom_range(1);
         {i_reg_sel, i_imm, i_pc, i_base_pc} = 28'($urandom);
         {i_index, i_aux_ram_disable, i_aux_page_select} = 12'($urandom);
         wd = 8'($urandom);
         case ($urandom_range(3))
            0: i_direct = 8'h7f + 8'($urandom_range(1));
            1: i_direct = 8'hd0 + 8'($urandom_range(7));
            default: i_direct = 8'($urandom);
         endcase
         i_dptr = $urandom_range(1) ? 16'h06ff + 16'($urandom_range(1)) :
            16'($urandom);
         op();
      end
      wrap_up();
   end
endmodule
